// >>> core/ppmc_pkg.sv
// Constants, field layout and types of the parallel port mode configuration block
package ppmc_pkg;

  // ****************************************************************
  // Port widths
  // ****************************************************************
  localparam int PORT_W = 8;
  localparam int HALF_W = 4;

  // ****************************************************************
  // Register offsets on the external bus (low address bits)
  // ****************************************************************
  localparam logic [1:0] OFS_FIRST_PORT = 2'h0;
  localparam logic [1:0] OFS_SECOND_PORT = 2'h1;
  localparam logic [1:0] OFS_THIRD_PORT = 2'h2;
  localparam logic [1:0] OFS_CONFIG = 2'h3;

  // ****************************************************************
  // Configuration word fields
  // ****************************************************************
  localparam int BIT_MODE_DEFINE = 7;
  localparam int BIT_FIRST_MODE_UPPER = 6;
  localparam int BIT_FIRST_MODE_LOWER = 5;
  localparam int BIT_FIRST_DIR = 4;
  localparam int BIT_THIRD_UPPER_DIR = 3;
  localparam int BIT_SECOND_MODE = 2;
  localparam int BIT_SECOND_DIR = 1;
  localparam int BIT_THIRD_LOWER_DIR = 0;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  // Mode define set, mode 0 everywhere, every direction bit input
  localparam logic [7:0] CONFIG_RESET = 8'h9b;
  localparam logic [7:0] LATCH_RESET = 8'h00;

  typedef enum logic [1:0] {PPMC_MODE0, PPMC_MODE1, PPMC_MODE2} ppmc_mode_t;

endpackage : ppmc_pkg

// >>> core/ppmc_cfg_if.sv
// Decoded configuration passed from the decoder to the port logic
`timescale 1ns/10ps
interface ppmc_cfg_if;
  ppmc_pkg::ppmc_mode_t first_mode;
  logic second_mode;
  logic first_in;
  logic second_in;
  logic third_upper_in;
  logic third_lower_in;
  modport src (output first_mode, output second_mode, output first_in, output second_in,
               output third_upper_in, output third_lower_in);
  modport dst (input first_mode, input second_mode, input first_in, input second_in,
               input third_upper_in, input third_lower_in);
endinterface : ppmc_cfg_if

// >>> core/ppmc_cfg_decode.sv
// Decoder of the 8-bit configuration word into modes and directions
`timescale 1ns/10ps
module ppmc_cfg_decode
(
  // Configuration word
  input wire logic [7:0] cfg_word_i,
  // Decoded fields
  ppmc_cfg_if.src cfg_o
);

  function automatic ppmc_pkg::ppmc_mode_t ppmc_first_mode(input logic upper, input logic lower);
    if (upper)
    begin
      return ppmc_pkg::PPMC_MODE2;
    end
    return lower ? ppmc_pkg::PPMC_MODE1 : ppmc_pkg::PPMC_MODE0;
  endfunction : ppmc_first_mode

  // ****************************************************************
  // Field decode
  // ****************************************************************
  assign cfg_o.first_mode = ppmc_first_mode(cfg_word_i[ppmc_pkg::BIT_FIRST_MODE_UPPER],
                                            cfg_word_i[ppmc_pkg::BIT_FIRST_MODE_LOWER]);
  assign cfg_o.second_mode = cfg_word_i[ppmc_pkg::BIT_SECOND_MODE];
  assign cfg_o.first_in = cfg_word_i[ppmc_pkg::BIT_FIRST_DIR];
  assign cfg_o.second_in = cfg_word_i[ppmc_pkg::BIT_SECOND_DIR];
  assign cfg_o.third_upper_in = cfg_word_i[ppmc_pkg::BIT_THIRD_UPPER_DIR];
  assign cfg_o.third_lower_in = cfg_word_i[ppmc_pkg::BIT_THIRD_LOWER_DIR];

endmodule : ppmc_cfg_decode

// >>> core/ppmc_top.sv
// Three-port parallel interface: configuration word, output latches and read-back
// Overview of operation
// - Config word bits, high to low: flag, mode hi, mode lo, A, C-high, M3, B, C-low.
// - A config word acts as mode definition only when its flag bit is 1.
// - First group upper mode bit 1 gives mode 2, lower bit ignored.
// - First port direction bit 1 makes it input, 0 output.
// - Third port upper half direction bit 1 input, 0 output.
// - Second group mode bit 1 gives mode 1, 0 gives mode 0.
// - Second port direction bit 1 makes it input, 0 output.
// - Third port lower half direction bit 1 input, 0 output.
// - Reset gives mode 0 and all ports input, nothing driven.
// - Mode 0 latches outputs, reads inputs unlatched (third port only when both groups are in mode 0), no handshake lines.
`timescale 1ns/10ps
module ppmc_top
#(
  parameter int PORT_W = ppmc_pkg::PORT_W
)
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Processor bus
  input wire logic bus_cs_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  input wire logic [1:0] bus_addr_i,
  input wire logic [7:0] bus_wdata_i,
  output logic [7:0] bus_rdata_o,
  // First port
  input wire logic [PORT_W-1:0] first_port_value_i,
  output logic [PORT_W-1:0] first_port_value_o,
  output logic [PORT_W-1:0] first_port_oe_o,
  // Second port
  input wire logic [PORT_W-1:0] second_port_value_i,
  output logic [PORT_W-1:0] second_port_value_o,
  output logic [PORT_W-1:0] second_port_oe_o,
  // Third port
  input wire logic [PORT_W-1:0] third_port_value_i,
  output logic [PORT_W-1:0] third_port_value_o,
  output logic [PORT_W-1:0] third_port_oe_o,
  // Mode status
  output ppmc_pkg::ppmc_mode_t first_group_mode_o,
  output logic second_group_mode_o
);

  localparam int H = ppmc_pkg::HALF_W;

  typedef struct packed {
    logic [7:0] cfg;
    logic [PORT_W-1:0] out_a;
    logic [PORT_W-1:0] out_b;
    logic [PORT_W-1:0] out_c;
    logic [PORT_W-1:0] oe_a;
    logic [PORT_W-1:0] oe_b;
    logic [PORT_W-1:0] oe_c;
    logic [PORT_W-1:0] in_a;
    logic [PORT_W-1:0] in_b;
    logic [PORT_W-1:0] in_c;
    logic [7:0] rdata;
    ppmc_pkg::ppmc_mode_t mode_a;
    logic mode_b;
  } ppmc_state_t;

  ppmc_state_t st;
  ppmc_state_t next_st;
  logic cfg_write;
  logic [7:0] cfg_candidate;

  ppmc_cfg_if dec_if ();

  // Read mux per line: driven lines read back their latch, the rest the input value passed in (pins or captured input)
  function automatic logic [PORT_W-1:0] ppmc_read_lane(input logic [PORT_W-1:0] oe,
                                                       input logic [PORT_W-1:0] outv,
                                                       input logic [PORT_W-1:0] inv);
    return (oe & outv) | (~oe & inv);
  endfunction : ppmc_read_lane

  // ****************************************************************
  // Configuration decode
  // ****************************************************************
  // Decoding the word being written, not the stored one, lets the new
  // directions land on the same edge as the word itself
  assign cfg_write = bus_cs_i && bus_wr_i && (bus_addr_i == ppmc_pkg::OFS_CONFIG) &&
                     bus_wdata_i[ppmc_pkg::BIT_MODE_DEFINE];
  assign cfg_candidate = cfg_write ? bus_wdata_i : st.cfg;

  ppmc_cfg_decode u_decode
  (
    .cfg_word_i(cfg_candidate),
    .cfg_o(dec_if.src)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    next_st = st;
    // Capture for modes 1 and 2; mode 0 reads bypass this register, the third port only with both groups in mode 0
    next_st.in_a = first_port_value_i;
    next_st.in_b = second_port_value_i;
    next_st.in_c = third_port_value_i;
    // Directions and modes all follow one decode, so they switch together
    next_st.cfg = cfg_candidate;
    next_st.mode_a = dec_if.first_mode;
    next_st.mode_b = dec_if.second_mode;
    next_st.oe_a = {PORT_W{~dec_if.first_in}};
    next_st.oe_b = {PORT_W{~dec_if.second_in}};
    next_st.oe_c = {{(PORT_W-H){~dec_if.third_upper_in}}, {H{~dec_if.third_lower_in}}};
    if (cfg_write)
    begin
      // A mode definition starts from cleared output latches
      // Cleared so that a port turned to output never drives a stale value
      next_st.out_a = ppmc_pkg::LATCH_RESET;
      next_st.out_b = ppmc_pkg::LATCH_RESET;
      next_st.out_c = ppmc_pkg::LATCH_RESET;
    end
    else if (bus_cs_i && bus_wr_i)
    begin
      case (bus_addr_i)
        ppmc_pkg::OFS_FIRST_PORT: next_st.out_a = bus_wdata_i;
        ppmc_pkg::OFS_SECOND_PORT: next_st.out_b = bus_wdata_i;
        ppmc_pkg::OFS_THIRD_PORT: next_st.out_c = bus_wdata_i;
        default: next_st.out_a = st.out_a;
      endcase
    end
    if (bus_cs_i && bus_rd_i)
    begin
      case (bus_addr_i)
        ppmc_pkg::OFS_FIRST_PORT:
          next_st.rdata = ppmc_read_lane(st.oe_a, st.out_a,
                            (st.mode_a == ppmc_pkg::PPMC_MODE0) ? first_port_value_i : st.in_a);
        ppmc_pkg::OFS_SECOND_PORT:
          next_st.rdata = ppmc_read_lane(st.oe_b, st.out_b, st.mode_b ? st.in_b : second_port_value_i);
        ppmc_pkg::OFS_THIRD_PORT:
          next_st.rdata = ppmc_read_lane(st.oe_c, st.out_c,
                            (st.mode_a == ppmc_pkg::PPMC_MODE0 && !st.mode_b) ?
                            third_port_value_i : st.in_c);
        default: next_st.rdata = st.cfg;
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      st <= '0;
      st.cfg <= ppmc_pkg::CONFIG_RESET;
      st.mode_a <= ppmc_pkg::PPMC_MODE0;
      st.mode_b <= 1'b0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign bus_rdata_o = st.rdata;
  assign first_port_value_o = st.out_a;
  assign second_port_value_o = st.out_b;
  assign third_port_value_o = st.out_c;
  assign first_port_oe_o = st.oe_a;
  assign second_port_oe_o = st.oe_b;
  assign third_port_oe_o = st.oe_c;
  assign first_group_mode_o = st.mode_a;
  assign second_group_mode_o = st.mode_b;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  sequence cfg_word_written;
    bus_cs_i && bus_wr_i && bus_addr_i == ppmc_pkg::OFS_CONFIG && bus_wdata_i[ppmc_pkg::BIT_MODE_DEFINE];
  endsequence

  sequence cfg_word_seen;
    st.cfg == $past(bus_wdata_i) && first_port_oe_o == {PORT_W{~$past(bus_wdata_i[ppmc_pkg::BIT_FIRST_DIR])}};
  endsequence

  cfg_apply_together_a: assert property (cfg_word_written |=> cfg_word_seen)
    else $error("config word not applied next cycle");
  cfg_flag_only_a: assert property (bus_cs_i && bus_wr_i && bus_addr_i == ppmc_pkg::OFS_CONFIG &&
      !bus_wdata_i[ppmc_pkg::BIT_MODE_DEFINE] |=> $stable(st.cfg) && $stable(first_port_oe_o))
    else $error("config changed without mode define flag");
  first_mode_two_a: assert property (st.cfg[ppmc_pkg::BIT_FIRST_MODE_UPPER] |->
      first_group_mode_o == ppmc_pkg::PPMC_MODE2)
    else $error("first group not in mode 2");
  first_mode_low_a: assert property (!st.cfg[ppmc_pkg::BIT_FIRST_MODE_UPPER] |->
      first_group_mode_o == (st.cfg[ppmc_pkg::BIT_FIRST_MODE_LOWER] ? ppmc_pkg::PPMC_MODE1 : ppmc_pkg::PPMC_MODE0))
    else $error("first group mode 0/1 wrong");
  second_mode_a: assert property (second_group_mode_o == st.cfg[ppmc_pkg::BIT_SECOND_MODE])
    else $error("second group mode wrong");
  second_dir_a: assert property (second_port_oe_o == {PORT_W{~st.cfg[ppmc_pkg::BIT_SECOND_DIR]}})
    else $error("second port direction wrong");
  third_upper_dir_a: assert property (third_port_oe_o[PORT_W-1:H] ==
      {(PORT_W-H){~st.cfg[ppmc_pkg::BIT_THIRD_UPPER_DIR]}})
    else $error("third port upper direction wrong");
  third_lower_dir_a: assert property (third_port_oe_o[H-1:0] == {H{~st.cfg[ppmc_pkg::BIT_THIRD_LOWER_DIR]}})
    else $error("third port lower direction wrong");
  first_write_latch_a: assert property (bus_cs_i && bus_wr_i && bus_addr_i == ppmc_pkg::OFS_FIRST_PORT
      |=> first_port_value_o == $past(bus_wdata_i) ##1 $stable(first_port_value_o) || $past(bus_cs_i && bus_wr_i))
    else $error("first port latch not held");
  mode0_read_pass_a: assert property (bus_cs_i && bus_rd_i && bus_addr_i == ppmc_pkg::OFS_FIRST_PORT &&
      first_group_mode_o == ppmc_pkg::PPMC_MODE0 && first_port_oe_o == '0 |=> bus_rdata_o == $past(first_port_value_i))
    else $error("mode 0 input read not direct");
  // Checked on every cycle, so a stray update between writes shows as well
  first_dir_a: assert property (first_port_oe_o == {PORT_W{~st.cfg[ppmc_pkg::BIT_FIRST_DIR]}})
    else $error("first port direction wrong");
  cfg_read_back_a: assert property (bus_cs_i && bus_rd_i && bus_addr_i == ppmc_pkg::OFS_CONFIG
      |=> bus_rdata_o == $past(st.cfg))
    else $error("config word read back wrong");

endmodule : ppmc_top

// >>> bench/ppmc_ttl_line.sv
// Model of the TTL I/O lines on one port connector
`timescale 1ns/10ps
module ppmc_ttl_line
(
  // Device side
  input wire logic [7:0] value_i,
  input wire logic [7:0] oe_i,
  // Field side
  input wire logic [7:0] field_i,
  output logic [7:0] pin_o
);
  // Field driver stands off on every line the device drives, so no contention
  always_comb
  begin
    pin_o = (value_i & oe_i) | (field_i & ~oe_i);
  end
endmodule : ppmc_ttl_line

// >>> bench/testbench.sv
// Self-checking bench for the parallel port mode configuration block
`timescale 1ns/10ps
module testbench;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic bus_cs_i = 1'b0;
  logic bus_wr_i = 1'b0;
  logic bus_rd_i = 1'b0;
  logic [1:0] bus_addr_i = 2'h0;
  logic [7:0] bus_wdata_i = 8'h00;
  logic [7:0] bus_rdata_o;
  logic [7:0] field [3] = '{8'h5a, 8'hc3, 8'h96};
  logic [7:0] val_o [3];
  logic [7:0] oe_o [3];
  logic [7:0] pin [3];
  ppmc_pkg::ppmc_mode_t first_mode;
  logic second_mode;
  logic [7:0] cfg_tab [11] = '{8'h80, 8'h90, 8'h88, 8'h84, 8'h82, 8'h81, 8'ha0, 8'hc0, 8'he0, 8'hb2, 8'hd6};
  logic [7:0] rd;
  logic [7:0] c;
  int err_count = 0;
  int check_count = 0;
  // ****************************************************************
  // Design, field lines and clock
  // ****************************************************************
  ppmc_top uut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .bus_cs_i(bus_cs_i), .bus_wr_i(bus_wr_i),
    .bus_rd_i(bus_rd_i), .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i), .bus_rdata_o(bus_rdata_o),
    .first_port_value_i(pin[0]), .first_port_value_o(val_o[0]), .first_port_oe_o(oe_o[0]),
    .second_port_value_i(pin[1]), .second_port_value_o(val_o[1]), .second_port_oe_o(oe_o[1]),
    .third_port_value_i(pin[2]), .third_port_value_o(val_o[2]), .third_port_oe_o(oe_o[2]),
    .first_group_mode_o(first_mode), .second_group_mode_o(second_mode));
  for (genvar g = 0; g < 3; g++)
  begin : g_line
    ppmc_ttl_line line (.value_i(val_o[g]), .oe_i(oe_o[g]), .field_i(field[g]), .pin_o(pin[g]));
  end
  initial
  begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // ****************************************************************
  // Bus tasks and checks
  // ****************************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus_write(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    bus_cs_i <= 1'b1;
    bus_wr_i <= 1'b1;
    bus_addr_i <= a;
    bus_wdata_i <= d;
    @(posedge clk_sys_i);
    bus_cs_i <= 1'b0;
    bus_wr_i <= 1'b0;
    #1;
  endtask : bus_write
  task automatic bus_read(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    bus_cs_i <= 1'b1;
    bus_rd_i <= 1'b1;
    bus_addr_i <= a;
    @(posedge clk_sys_i);
    bus_cs_i <= 1'b0;
    bus_rd_i <= 1'b0;
    #1;
    d = bus_rdata_o;
  endtask : bus_read
  // Held low for 16 cycles; checked before the first edge after release
  task automatic reset_check;
    @(posedge clk_sys_i);
    reset_n_i <= 1'b0;
    repeat (16) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    #1;
    for (int p = 0; p < 3; p++)
    begin
      check(oe_o[p], 8'h00);
    end
    check({6'h00, first_mode}, 8'h00);
    check({7'h00, second_mode}, 8'h00);
    bus_read(ppmc_pkg::OFS_CONFIG, rd);
    check(rd, ppmc_pkg::CONFIG_RESET);
    bus_read(ppmc_pkg::OFS_FIRST_PORT, rd);
    check(rd, field[0]);
    $display("test reset done");
  endtask : reset_check
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial
  begin
    repeat (4000) @(posedge clk_sys_i);
    err_count++;
    give_verdict;
  end
  initial
  begin
    reset_check;
    // All outputs, then latch each port and read back the second port
    bus_write(ppmc_pkg::OFS_CONFIG, 8'h80);
    bus_write(ppmc_pkg::OFS_FIRST_PORT, 8'h3c);
    bus_write(ppmc_pkg::OFS_SECOND_PORT, 8'ha5);
    bus_write(ppmc_pkg::OFS_THIRD_PORT, 8'h69);
    check(val_o[0], 8'h3c);
    check(val_o[1], 8'ha5);
    check(val_o[2], 8'h69);
    bus_read(ppmc_pkg::OFS_SECOND_PORT, rd);
    check(rd, 8'ha5);
    // Flag clear must leave the word alone
    bus_write(ppmc_pkg::OFS_CONFIG, 8'h1b);
    check(oe_o[0], 8'hff);
    check(val_o[0], 8'h3c);
    bus_read(ppmc_pkg::OFS_CONFIG, rd);
    check(rd, 8'h80);
    $display("test latch and flag done");
    foreach (cfg_tab[i])
    begin
      c = cfg_tab[i];
      bus_write(ppmc_pkg::OFS_CONFIG, c);
      check(oe_o[0], c[4] ? 8'h00 : 8'hff);
      check(oe_o[1], c[1] ? 8'h00 : 8'hff);
      check(oe_o[2], {c[3] ? 4'h0 : 4'hf, c[0] ? 4'h0 : 4'hf});
      check({6'h00, first_mode}, c[6] ? 8'h02 : {7'h00, c[5]});
      check({7'h00, second_mode}, {7'h00, c[2]});
      bus_read(ppmc_pkg::OFS_CONFIG, rd);
      check(rd, c);
      bus_read(ppmc_pkg::OFS_FIRST_PORT, rd);
      check(rd, c[4] ? field[0] : 8'h00);
      bus_read(ppmc_pkg::OFS_SECOND_PORT, rd);
      check(rd, c[1] ? field[1] : 8'h00);
      bus_read(ppmc_pkg::OFS_THIRD_PORT, rd);
      check(rd, {c[3] ? field[2][7:4] : 4'h0, c[0] ? field[2][3:0] : 4'h0});
    end
    // Third port halves read back in mode 0 only
    bus_write(ppmc_pkg::OFS_CONFIG, 8'h81);
    bus_read(ppmc_pkg::OFS_THIRD_PORT, rd);
    check(rd, {4'h0, field[2][3:0]});
    bus_write(ppmc_pkg::OFS_CONFIG, 8'h88);
    bus_read(ppmc_pkg::OFS_THIRD_PORT, rd);
    check(rd, {field[2][7:4], 4'h0});
    $display("test configuration table done");
    reset_check;
    give_verdict;
  end
endmodule : testbench
